// ===== design/ubrg_defs.svh
// Constant macros for the serial port and its divisor generator
`ifndef UBRG_DEFS_SVH
`define UBRG_DEFS_SVH
// ****************************************
// Register indices, byte address = 4 * index
// ****************************************
`define UBRG_IDX_DATA 4'h0
`define UBRG_IDX_IER  4'h1
`define UBRG_IDX_IIR  4'h2
`define UBRG_IDX_LCR  4'h3
`define UBRG_IDX_MCR  4'h4
`define UBRG_IDX_LSR  4'h5
`define UBRG_IDX_MSR  4'h6
`define UBRG_IDX_SCR  4'h7
// ****************************************
// Field positions
// ****************************************
`define UBRG_LCR_BRK  6
`define UBRG_LCR_DLAB 7
`define UBRG_DLM_SEL  7
`define UBRG_MCR_GATE 3
`define UBRG_IER_RX   0
`define UBRG_IER_TX   1
`define UBRG_IER_LS   2
// ****************************************
// Reset values and interrupt codes
// ****************************************
`define UBRG_REG_RST  8'h00
`define UBRG_IIR_NONE 4'h1
`define UBRG_IIR_LS   4'h6
`define UBRG_IIR_RX   4'h4
`define UBRG_IIR_TX   4'h2
// ****************************************
// Rates in Hz (100000000, 1843200, 24000000) and tick counts
// ****************************************
`define UBRG_SYS_HZ   27'h5F5E100
`define UBRG_LO_HZ    27'h01C2000
`define UBRG_HI_HZ    27'h16E3600
`define UBRG_DIV0_EFF 16'h0003
`define UBRG_TK_HALF  6'h07
`define UBRG_TK_BIT   6'h0F
`define UBRG_TK_ST15  6'h17
`define UBRG_TK_ST2   6'h1F
`endif

// ===== design/ubrg_divgen.sv
// Source rate enables and programmable sixteen-times tick generator
`timescale 1ns/1ns
`default_nettype none
`include "ubrg_defs.svh"
module ubrg_divgen
   import ubrg_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_run,
   input  wire logic        i_sel_hi,
   input  wire logic        i_ext_choice,
   input  wire logic        i_ext_tick,
   input  wire logic        i_load,
   input  wire logic [15:0] i_div,
   output logic             o_tick
);
   logic [26:0] acc_lo;
   logic [26:0] acc_hi;
   logic [26:0] next_acc_lo;
   logic [26:0] next_acc_hi;
   logic        wrap_lo;
   logic        wrap_hi;
   logic        src_tick;
   logic        src_go;
   logic [15:0] cnt;
   logic [15:0] eff;
   logic [15:0] low;
   logic [15:0] next_cnt;
   // fractional accumulators give both source rates
   assign next_acc_lo = acc_lo + `UBRG_LO_HZ;
   assign next_acc_hi = acc_hi + `UBRG_HI_HZ;
   assign wrap_lo     = next_acc_lo >= `UBRG_SYS_HZ;
   assign wrap_hi     = next_acc_hi >= `UBRG_SYS_HZ;
   // source choice, the external choice overrides the select bit
   assign src_tick    = i_ext_choice ? i_ext_tick : (i_sel_hi ? wrap_hi : wrap_lo);
   assign src_go      = src_tick & i_run;
   // zero counts as three, low for two source periods
   assign eff         = (i_div == 16'h0000) ? `UBRG_DIV0_EFF : i_div;
   // divisor two is low one period, high one period
   assign low         = (eff == 16'h0002) ? 16'h0001 : 16'h0002;
   assign next_cnt    = (cnt == 16'h0000) ? eff - 16'h0001 : cnt - 16'h0001;
   // Accumulators
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         acc_lo <= 27'h0000000;
         acc_hi <= 27'h0000000;
      end else begin
         acc_lo <= wrap_lo ? next_acc_lo - `UBRG_SYS_HZ : next_acc_lo;
         acc_hi <= wrap_hi ? next_acc_hi - `UBRG_SYS_HZ : next_acc_hi;
      end
   end
   // counter, tick on the rise of the divided output
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt    <= 16'h0000;
         o_tick <= 1'b0;
      end else if (i_load) begin
         cnt    <= eff - 16'h0001;
         o_tick <= 1'b0;
      end else begin
         o_tick <= src_go & (eff == 16'h0001 || cnt == eff - low);
         if (src_go) cnt <= next_cnt;
      end
   end
   div_range_a: assert property (@(posedge i_clk) disable iff (i_rst) !i_load |-> cnt < eff)
      else $error("baud counter beyond divisor");
   div_reload_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_load |=> cnt == $past(eff) - 16'h0001)
      else $error("baud counter not reloaded");
   // tick only on a source period
   tick_src_a: assert property (@(posedge i_clk) disable iff (i_rst) o_tick |-> $past(src_go))
      else $error("tick without source period");
endmodule // ubrg_divgen
`default_nettype wire

// ===== design/ubrg_pkg.sv
// Types and parity function shared by the serial port files
`default_nettype none
package ubrg_pkg;
   typedef enum logic [2:0] {s_idle, s_start, s_data, s_par, s_stop} ubrg_ser_e;
   typedef struct packed {
      logic [1:0] wlen;
      logic       stop_long;
      logic       par_en;
      logic       par_even;
      logic       par_stick;
   } ubrg_frame_s;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       perr;
      logic       ferr;
   } ubrg_rxres_s;
   // Parity bit for the enabled data bits
   function automatic logic ubrg_par(input logic [7:0] d, input ubrg_frame_s f);
      logic [7:0] m;
      m = {f.wlen == 2'h3, f.wlen >= 2'h2, f.wlen != 2'h0, 5'h1F};
      if (f.par_stick) return ~f.par_even;
      return (^(d & m)) ^ ~f.par_even;
   endfunction
endpackage
`default_nettype wire

// ===== design/ubrg_rx.sv
// Receiver: mid-bit sampling and deserialising of one character
`timescale 1ns/1ns
`default_nettype none
`include "ubrg_defs.svh"
module ubrg_rx
   import ubrg_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_tick,
   input  wire logic        i_rxd,
   input  wire ubrg_frame_s i_cfg,
   output var ubrg_rxres_s  o_res
);
   ubrg_ser_e  st;
   logic [5:0] cnt;
   logic [2:0] idx;
   logic [7:0] sh;
   logic [7:0] data_al;
   logic       perr;
   logic [2:0] last_idx;
   // Right-align the shifted word for short characters
   assign data_al  = sh >> (2'h3 - i_cfg.wlen);
   assign last_idx = 3'h4 + {1'b0, i_cfg.wlen};
   // sample at eight ticks then every sixteen, LSB first
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st    <= s_idle;
         cnt   <= 6'h00;
         idx   <= 3'h0;
         sh    <= 8'h00;
         perr  <= 1'b0;
         o_res <= '0;
      end else begin
         o_res.valid <= 1'b0;
         if (i_tick) begin
            cnt <= cnt + 6'h01;
            case (st)
               s_idle: begin
                  cnt <= 6'h00;
                  if (!i_rxd) st <= s_start;
               end
               s_start: if (cnt == `UBRG_TK_HALF) begin
                  cnt  <= 6'h00;
                  idx  <= 3'h0;
                  perr <= 1'b0;
                  st   <= i_rxd ? s_idle : s_data;
               end
               s_data: if (cnt == `UBRG_TK_BIT) begin
                  cnt <= 6'h00;
                  sh  <= {i_rxd, sh[7:1]};
                  idx <= idx + 3'h1;
                  if (idx == last_idx) st <= i_cfg.par_en ? s_par : s_stop;
               end
               s_par: if (cnt == `UBRG_TK_BIT) begin
                  cnt  <= 6'h00;
                  perr <= i_rxd != ubrg_par(data_al, i_cfg);
                  st   <= s_stop;
               end
               default: if (cnt == `UBRG_TK_BIT) begin
                  o_res <= {1'b1, data_al, perr, ~i_rxd};
                  st    <= s_idle;
               end
            endcase
         end
      end
   end
   // a result comes only from the stop sample
   rx_result_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_res.valid |-> $past(st) == s_stop && $past(cnt) == `UBRG_TK_BIT)
      else $error("receive result outside stop sample");
endmodule // ubrg_rx
`default_nettype wire

// ===== design/ubrg_top.sv
// Serial port with programmable baud divisor behind a Wishbone slave
// Behaviour
// - Derive a 1.8432 MHz source for standard rates up to 115200 baud.
// - Derive a 24 MHz source for rates up to 1500000 baud.
// - Applying standby supply resets every register and all logic of the port.
// - One interrupt output is high while any enabled condition is pending.
// - Interrupt gate bit at 1 passes interrupts, at 0 holds output low.
// - One start bit, stop length of 1, 1.5 or 2 bit times.
// - Parity even, odd, forced or none per character.
// - Received serial becomes parallel; written words are sent serially.
// - Divider accepts any divisor from 1 through 32767.
// - Divider output runs at sixteen times the bit rate.
// - Divisor is fifteen bits in two byte latches loaded by software; bit 7 of the high latch is the select bit.
// - Writing either latch reloads the baud counter one clock after the latch takes the new value.
// - Divisor 0 divides the source by three.
// - Divisor 1 gives the inverse of the source clock.
// - Divisor 2 divides by two at half duty.
// - Divisor 3 or more is low two periods, high the rest.
// - MIDI rate reachable by divisor and source choice.
// - A low-power request from the power unit stops the port.
// - Select bit 7 of divisor high picks high source unless external choice.
// - Data bits travel least significant first on both directions.
`timescale 1ns/1ns
`default_nettype none
`include "ubrg_defs.svh"
module ubrg_top
   import ubrg_pkg::*;
(
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RST,
   input  wire logic        I_STANDBY_SUPPLY,
   input  wire logic        I_LOW_POWER_REQ,
   input  wire logic        I_EXT_CLK_CHOICE,
   input  wire logic        I_EXT_CLK_TICK,
   input  wire logic        I_RXD,
   input  wire logic        I_WB_CYC,
   input  wire logic        I_WB_STB,
   input  wire logic        I_WB_WE,
   input  wire logic [5:2]  I_WB_ADR,
   input  wire logic [3:0]  I_WB_SEL,
   input  wire logic [31:0] I_WB_DAT,
   output logic      [31:0] O_WB_DAT,
   output logic             O_WB_ACK,
   output logic             O_TXD,
   output logic             O_INTR,
   output logic             O_LOW_POWER_ACK
);
   // ****************************************
   // Declarations
   // ****************************************
   logic        block_system_reset;
   logic        stby_q;
   logic        rst_all;
   logic [7:0]  lcr;
   logic [3:0]  ier;
   logic [4:0]  mcr;
   logic [7:0]  scr;
   logic [7:0]  dll;
   logic [7:0]  dlm;
   logic [7:0]  rbr;
   logic [7:0]  thr;
   logic [7:0]  tx_sh;
   logic        dr;
   logic        oe;
   logic        pe;
   logic        fe;
   logic        thr_full;
   logic        thre_int;
   logic        div_load;
   logic        tx_line;
   logic        tx_par;
   ubrg_ser_e   tx_st;
   logic [5:0]  tx_cnt;
   logic [2:0]  tx_idx;
   logic [2:0]  last_idx;
   logic [5:0]  stop_end;
   ubrg_frame_s cfg;
   ubrg_rxres_s rx_res;
   logic        tick16;
   logic        req;
   logic        wr;
   logic        rd;
   logic        dlab;
   logic        wr_thr;
   logic        wr_dll;
   logic        wr_dlm;
   logic        rd_rbr;
   logic        rd_iir;
   logic        rd_lsr;
   logic        tx_take;
   logic        pend_ls;
   logic        pend_rx;
   logic        pend_tx;
   logic        pend_any;
   logic [3:0]  iir;
   logic [7:0]  lsr;
   logic [7:0]  rdata;

   // Index compare used by every decode term
   function automatic logic at(input logic [3:0] a, input logic [3:0] idx);
      return a == idx;
   endfunction

   // ****************************************
   // Block reset
   // ****************************************
   // standby supply edge resets the block
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         stby_q             <= I_STANDBY_SUPPLY; // Supply present at reset is no edge
         block_system_reset <= 1'b0;
      end else begin
         stby_q             <= I_STANDBY_SUPPLY;
         block_system_reset <= I_STANDBY_SUPPLY & ~stby_q;
      end
   end
   assign rst_all = I_RST | block_system_reset;

   // ****************************************
   // Bus decode
   // ****************************************
   // Wishbone request, one access per acknowledge
   assign req    = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
   assign wr     = req & I_WB_WE & I_WB_SEL[0];
   assign rd     = req & ~I_WB_WE;
   assign dlab   = lcr[`UBRG_LCR_DLAB];
   assign wr_thr = wr & at(I_WB_ADR, `UBRG_IDX_DATA) & ~dlab;
   assign wr_dll = wr & at(I_WB_ADR, `UBRG_IDX_DATA) & dlab;
   assign wr_dlm = wr & at(I_WB_ADR, `UBRG_IDX_IER) & dlab;
   assign rd_rbr = rd & at(I_WB_ADR, `UBRG_IDX_DATA) & ~dlab;
   assign rd_iir = rd & at(I_WB_ADR, `UBRG_IDX_IIR);
   assign rd_lsr = rd & at(I_WB_ADR, `UBRG_IDX_LSR);

   // Status words
   assign lsr = {1'b0, ~thr_full & (tx_st == s_idle), ~thr_full, 1'b0, fe, pe, oe, dr};
   assign pend_ls  = ier[`UBRG_IER_LS] & (oe | pe | fe);
   assign pend_rx  = ier[`UBRG_IER_RX] & dr;
   assign pend_tx  = ier[`UBRG_IER_TX] & thre_int;
   assign pend_any = pend_ls | pend_rx | pend_tx;
   assign iir = pend_ls ? `UBRG_IIR_LS : pend_rx ? `UBRG_IIR_RX :
                pend_tx ? `UBRG_IIR_TX : `UBRG_IIR_NONE;

   // Read data selection
   always_comb begin
      rdata = 8'h00;
      if (at(I_WB_ADR, `UBRG_IDX_DATA)) begin
         rdata = dlab ? dll : rbr;
      end else if (at(I_WB_ADR, `UBRG_IDX_IER)) begin
         rdata = dlab ? dlm : {4'h0, ier};
      end else if (at(I_WB_ADR, `UBRG_IDX_IIR)) begin
         rdata = {4'h0, iir};
      end else if (at(I_WB_ADR, `UBRG_IDX_LCR)) begin
         rdata = lcr;
      end else if (at(I_WB_ADR, `UBRG_IDX_MCR)) begin
         rdata = {3'h0, mcr};
      end else if (at(I_WB_ADR, `UBRG_IDX_LSR)) begin
         rdata = lsr;
      end else if (at(I_WB_ADR, `UBRG_IDX_SCR)) begin
         rdata = scr;
      end
   end

   // Acknowledge and read data, unmapped reads give zero
   always_ff @(posedge I_CLK_SYS) begin
      if (rst_all) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h00000000;
      end else begin
         O_WB_ACK <= req;
         O_WB_DAT <= {24'h000000, rdata};
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   // byte latches of the divisor, load pulse follows the write
   always_ff @(posedge I_CLK_SYS) begin
      if (rst_all) begin
         lcr      <= `UBRG_REG_RST;
         ier      <= 4'h0;
         mcr      <= 5'h00;
         scr      <= `UBRG_REG_RST;
         dll      <= `UBRG_REG_RST;
         dlm      <= `UBRG_REG_RST;
         div_load <= 1'b0;
      end else begin
         div_load <= wr_dll | wr_dlm;
         if (wr_dll) dll <= I_WB_DAT[7:0];
         if (wr_dlm) dlm <= I_WB_DAT[7:0];
         if (wr & at(I_WB_ADR, `UBRG_IDX_IER) & ~dlab) ier <= I_WB_DAT[3:0];
         if (wr & at(I_WB_ADR, `UBRG_IDX_LCR)) lcr <= I_WB_DAT[7:0];
         if (wr & at(I_WB_ADR, `UBRG_IDX_MCR)) mcr <= I_WB_DAT[4:0];
         if (wr & at(I_WB_ADR, `UBRG_IDX_SCR)) scr <= I_WB_DAT[7:0];
      end
   end

   // character framing from the line control
   assign cfg.wlen      = lcr[1:0];
   assign cfg.stop_long = lcr[2];
   assign cfg.par_en    = lcr[3];
   assign cfg.par_even  = lcr[4];
   assign cfg.par_stick = lcr[5];

   // ****************************************
   // Divisor generator and receiver
   // ****************************************
   // select bit and divisor, e.g. 48 on the high source for MIDI
   ubrg_divgen u_divgen (
      .i_clk        (I_CLK_SYS),
      .i_rst        (rst_all),
      .i_run        (~O_LOW_POWER_ACK),
      .i_sel_hi     (dlm[`UBRG_DLM_SEL]),
      .i_ext_choice (I_EXT_CLK_CHOICE),
      .i_ext_tick   (I_EXT_CLK_TICK),
      .i_load       (div_load),
      .i_div        ({1'b0, dlm[6:0], dll}),
      .o_tick       (tick16)
   );

   ubrg_rx u_rx (
      .i_clk (I_CLK_SYS),
      .i_rst (rst_all),
      .i_tick(tick16),
      .i_rxd (I_RXD),
      .i_cfg (cfg),
      .o_res (rx_res)
   );

   // receive flags, a new event wins over a read clear
   always_ff @(posedge I_CLK_SYS) begin
      if (rst_all) begin
         rbr <= `UBRG_REG_RST;
         dr  <= 1'b0;
         oe  <= 1'b0;
         pe  <= 1'b0;
         fe  <= 1'b0;
      end else begin
         if (rx_res.valid) rbr <= rx_res.data;
         dr <= rx_res.valid | (dr & ~rd_rbr);
         oe <= (rx_res.valid & dr & ~rd_rbr) | (oe & ~rd_lsr);
         pe <= (rx_res.valid & rx_res.perr) | (pe & ~rd_lsr);
         fe <= (rx_res.valid & rx_res.ferr) | (fe & ~rd_lsr);
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   assign tx_take  = tick16 & (tx_st == s_idle) & thr_full;
   assign last_idx = 3'h4 + {1'b0, cfg.wlen};
   // stop ticks: 16, or 24 for five-bit words, else 32
   assign stop_end = ~cfg.stop_long ? `UBRG_TK_BIT :
                     (cfg.wlen == 2'h0) ? `UBRG_TK_ST15 : `UBRG_TK_ST2;

   // Holding register and empty interrupt, set wins over clear
   always_ff @(posedge I_CLK_SYS) begin
      if (rst_all) begin
         thr      <= `UBRG_REG_RST;
         thr_full <= 1'b0;
         thre_int <= 1'b0;
      end else begin
         if (wr_thr) thr <= I_WB_DAT[7:0];
         thr_full <= wr_thr | (thr_full & ~tx_take);
         thre_int <= tx_take | (thre_int & ~wr_thr & ~(rd_iir & iir == `UBRG_IIR_TX));
      end
   end

   // shift out LSB first with start, parity and stop
   always_ff @(posedge I_CLK_SYS) begin
      if (rst_all) begin
         tx_st   <= s_idle;
         tx_cnt  <= 6'h00;
         tx_idx  <= 3'h0;
         tx_sh   <= 8'h00;
         tx_line <= 1'b1;
         tx_par  <= 1'b0;
      end else if (tick16) begin
         tx_cnt <= tx_cnt + 6'h01;
         case (tx_st)
            s_idle: begin
               tx_cnt <= 6'h00;
               if (thr_full) begin
                  tx_st   <= s_start;
                  tx_sh   <= thr;
                  tx_par  <= ubrg_par(thr, cfg);
                  tx_line <= 1'b0;
               end
            end
            s_start: if (tx_cnt == `UBRG_TK_BIT) begin
               tx_cnt  <= 6'h00;
               tx_idx  <= 3'h0;
               tx_st   <= s_data;
               tx_line <= tx_sh[0];
            end
            s_data: if (tx_cnt == `UBRG_TK_BIT) begin
               tx_cnt <= 6'h00;
               if (tx_idx == last_idx) begin
                  tx_st   <= cfg.par_en ? s_par : s_stop;
                  tx_line <= cfg.par_en ? tx_par : 1'b1;
               end else begin
                  tx_idx  <= tx_idx + 3'h1;
                  tx_sh   <= tx_sh >> 1;
                  tx_line <= tx_sh[1];
               end
            end
            s_par: if (tx_cnt == `UBRG_TK_BIT) begin
               tx_cnt  <= 6'h00;
               tx_st   <= s_stop;
               tx_line <= 1'b1;
            end
            default: if (tx_cnt == stop_end) begin
               tx_cnt <= 6'h00;
               tx_st  <= s_idle;
            end
         endcase
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // gated interrupt, low power once the transmitter is idle
   always_ff @(posedge I_CLK_SYS) begin
      if (rst_all) begin
         O_TXD           <= 1'b1;
         O_INTR          <= 1'b0;
         O_LOW_POWER_ACK <= 1'b0;
      end else begin
         O_TXD           <= tx_line & ~lcr[`UBRG_LCR_BRK];
         O_INTR          <= mcr[`UBRG_MCR_GATE] & pend_any;
         O_LOW_POWER_ACK <= I_LOW_POWER_REQ & (tx_st == s_idle) & ~thr_full;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence wb_req_s;
      I_WB_CYC && I_WB_STB && !O_WB_ACK;
   endsequence
   sequence wb_ack_s;
      O_WB_ACK ##1 !O_WB_ACK;
   endsequence
   bus_answer_a: assert property (@(posedge I_CLK_SYS) disable iff (rst_all) wb_req_s |=> wb_ack_s)
      else $error("bus request not answered in one cycle");
   // gate bit low keeps interrupt low
   intr_gate_a: assert property (@(posedge I_CLK_SYS) disable iff (rst_all)
      !mcr[`UBRG_MCR_GATE] |=> !O_INTR)
      else $error("interrupt passed a closed gate");
   intr_pend_a: assert property (@(posedge I_CLK_SYS) disable iff (rst_all)
      mcr[`UBRG_MCR_GATE] && pend_any |=> O_INTR)
      else $error("pending interrupt not signalled");
   // start bit is low, stop is high
   start_bit_a: assert property (@(posedge I_CLK_SYS) disable iff (rst_all)
      tx_st == s_start && !lcr[`UBRG_LCR_BRK] |=> !O_TXD)
      else $error("start bit not low");
   stop_bit_a: assert property (@(posedge I_CLK_SYS) disable iff (rst_all)
      tx_st == s_stop && !lcr[`UBRG_LCR_BRK] |=> O_TXD)
      else $error("stop bit not high");
   rx_ready_a: assert property (@(posedge I_CLK_SYS) disable iff (rst_all)
      rx_res.valid |=> dr && rbr == $past(rx_res.data))
      else $error("received word not stored");
endmodule // ubrg_top
`default_nettype wire

// ===== tb/uart_baud_rate_generator_bench.sv
// Self-checking bench for the serial port and its divisor generator
`timescale 1ns/1ns
`default_nettype none
module uart_baud_rate_generator_bench;
   logic        clk = 0, rst = 1, stby = 1, lpr = 0, ext = 0;
   logic        cyc = 0, stb = 0, we = 0, ack, txd, intr, lpa;
   logic [3:0]  adr = 0;
   logic [31:0] wdat = 0, rdat, q;
   logic [7:0]  b;
   logic [5:0]  lc;
   logic [8:0]  f;
   wire         rxd;
   int          fail_count = 0;
   int          tests_run = 0;
   // Clock generator
   always #5 clk = ~clk;
   ubrg_line_partner line_u (.i_clk(clk), .o_line(rxd));
   ubrg_top dut_u (.I_CLK_SYS(clk), .I_RST(rst), .I_STANDBY_SUPPLY(stby), .I_LOW_POWER_REQ(lpr),
      .I_EXT_CLK_CHOICE(ext), .I_EXT_CLK_TICK(1'b0), .I_RXD(rxd), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
      .O_WB_ACK(ack), .O_TXD(txd), .O_INTR(intr), .O_LOW_POWER_ACK(lpa));
   // bit time in clocks: 16 ticks of the 24 MHz or 1.8432 MHz source over the divisor
   function automatic int bit_clks(input int d, input logic hi);
      return hi ? (1600 * d + 12) / 24 : (1000000 * d + 576) / 1152;
   endfunction
   // data bits then parity in line order, unused bits zero
   function automatic logic [8:0] exp_bits(input logic [7:0] d, input logic [5:0] c);
      logic [8:0] e;
      int         n;
      n = 5 + c[1:0];
      e = 9'h000;
      for (int i = 0; i < n; i++)
         e[i] = d[i];
      if (c[3])
         e[n] = c[5] ? ~c[4] : (^e[7:0]) ^ ~c[4];
      return e;
   endfunction
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      chk(n < 50, 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   // Decode one character from the transmit line
   task automatic get_tx(input int nb, input int bc, output logic [8:0] c);
      int n;
      n = 0;
      c = 9'h000;
      while (txd !== 1'b0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      chk(n < 2000, 1'b1);
      repeat (bc * 3 / 2) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         c[i] = txd;
         repeat (bc) @(posedge clk);
      end
      chk(txd, 1'b1);
   endtask
   // Counts and verdict
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
   // Test sequence
   initial begin
      void'($urandom(87610));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(txd, 1'b1);
      wb(0, 4'h3, 0);
      chk(q, 0);
      wb(0, 4'h9, 0);
      chk(q, 0);
      $display("test reset done");
      wb(1, 4'h3, 8'h80);
      wb(1, 4'h0, 8'h01);
      wb(1, 4'h1, 8'h80);
      wb(0, 4'h0, 0);
      chk(q, 32'h01);
      wb(0, 4'h1, 0);
      chk(q, 32'h80);
      wb(1, 4'h3, 8'h03);
      $display("test divisor done");
      for (int k = 0; k < 6; k++) begin
         lc = (k == 0) ? 6'h03 : 6'($urandom);
         b = (k == 0) ? 8'h01 : 8'($urandom);
         wb(1, 4'h3, {2'b00, lc});
         wb(1, 4'h0, b);
         get_tx(5 + lc[1:0] + lc[3], bit_clks(1, 1), f);
         chk(f, exp_bits(b, lc));
      end
      $display("test transmit done");
      wb(1, 4'h3, 8'h03);
      wb(1, 4'h1, 8'h01);
      for (int k = 0; k < 2; k++) begin
         b = 8'($urandom);
         wb(1, 4'h4, 8'h00);
         line_u.send(b, bit_clks(1, 1));
         repeat (4) @(posedge clk);
         chk(intr, 1'b0);
         wb(1, 4'h4, 8'h08);
         repeat (3) @(posedge clk);
         chk(intr, 1'b1);
         wb(0, 4'h0, 0);
         chk(q, {24'h0, b});
         repeat (3) @(posedge clk);
         chk(intr, 1'b0);
      end
      $display("test receive done");
      ext <= 1'b1;
      b = 8'($urandom);
      wb(1, 4'h0, b);
      repeat (200) @(posedge clk);
      wb(0, 4'h5, 0);
      chk(q & 32'h60, 0);
      ext <= 1'b0;
      get_tx(8, bit_clks(1, 1), f);
      chk(f, exp_bits(b, 6'h03));
      $display("test source choice done");
      wb(1, 4'h3, 8'h83);
      wb(1, 4'h0, 8'h01);
      wb(1, 4'h1, 8'h00);
      wb(1, 4'h3, 8'h03);
      b = 8'($urandom);
      wb(1, 4'h0, b);
      get_tx(8, bit_clks(1, 0), f);
      chk(f, exp_bits(b, 6'h03));
      $display("test low source done");
      lpr <= 1'b1;
      repeat (1000) @(posedge clk);
      chk(lpa, 1'b1);
      lpr <= 1'b0;
      wb(1, 4'h7, 8'hA5);
      wb(0, 4'h7, 0);
      chk(q, 32'hA5);
      stby <= 1'b0;
      @(posedge clk);
      stby <= 1'b1;
      repeat (4) @(posedge clk);
      wb(0, 4'h7, 0);
      chk(q, 0);
      $display("test power done");
      report_and_stop();
   end
endmodule // uart_baud_rate_generator_bench
`default_nettype wire

// ===== tb/ubrg_line_partner.sv
// Serial line partner that sends characters to the port
`timescale 1ns/1ns
`default_nettype none
module ubrg_line_partner (
   input  wire logic i_clk,
   output logic      o_line
);
   // Line idles at the mark level
   initial o_line = 1'b1;
   task automatic send(input logic [7:0] b, input int clks);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_line <= f[i];
         repeat (clks) @(posedge i_clk);
      end
   endtask
endmodule // ubrg_line_partner
`default_nettype wire
